// ===== rtl/urm_regs.vh
// Register offsets, field positions and reset values for the UART register bank
`ifndef URM_REGS_VH
`define URM_REGS_VH
`define URM_A_RXTX      3'h0
`define URM_A_IER       3'h1
`define URM_A_ISR       3'h2
`define URM_A_LCR       3'h3
`define URM_A_MCR       3'h4
`define URM_A_LSR       3'h5
`define URM_A_MSR       3'h6
`define URM_A_SPR       3'h7
`define URM_A_EFR       3'h2
`define URM_A_RES1      3'h4
`define URM_A_RES2      3'h5
`define URM_A_PAU1      3'h6
`define URM_A_PAU2      3'h7
`define URM_LCR_DIV     7
`define URM_LCR_KEY     8'hbf
`define URM_EFR_ENH     4
`define URM_XFR_LSRMODE 3
`define URM_IER_RX      0
`define URM_IER_TX      1
`define URM_IER_LS      2
`define URM_IER_MS      3
`define URM_FCR_EN      0
`define URM_ZERO8       8'h00
`define URM_LCR_RST     8'h03
`define URM_ISR_NONE    4'h1
`define URM_ISR_LS      4'h6
`define URM_ISR_RXTO    4'hc
`define URM_ISR_RX      4'h4
`define URM_ISR_TX      4'h2
`define URM_ISR_MS      4'h0
`define URM_IER_LOW_M   8'h0f
`define URM_REVISION    8'h5a
`define URM_DEV_ID      8'h3c
`endif

// ===== rtl/urm_regbank.v
// UART register bank with interrupt enables, line status and source encoding
`timescale 1ns/10ps
`include "urm_regs.vh"

module urm_regbank (
	// Clock and reset
	input  wire       i_clock,
	input  wire       i_sys_rst,
	// Host parallel bus
	input  wire [2:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	// Receive datapath status
	input  wire       i_rx_push,
	input  wire       i_rx_empty,
	input  wire       i_rx_at_trigger,
	input  wire       i_rx_timeout,
	input  wire       i_rx_overrun,
	input  wire [2:0] i_rx_head_err,
	input  wire [2:0] i_rx_push_err,
	input  wire       i_rx_any_err,
	// Transmit datapath and modem status
	input  wire       i_tx_empty,
	input  wire       i_tx_below_trigger,
	input  wire       i_tsr_empty,
	input  wire       i_modem_pending,
	// Configuration toward the datapath
	output reg  [7:0] o_line_control,
	output reg  [7:0] o_baud_divisor_low,
	output reg  [7:0] o_baud_divisor_high,
	output reg  [7:0] o_enhanced_function_ctrl,
	output reg  [7:0] o_flow_resume_char_1,
	output reg  [7:0] o_flow_resume_char_2,
	output reg  [7:0] o_flow_pause_char_1,
	output reg  [7:0] o_flow_pause_char_2,
	output reg  [7:0] o_interrupt_enable_mask,
	output reg  [7:0] o_fifo_control,
	output reg  [7:0] o_modem_control,
	output reg  [7:0] o_extra_feature_ctrl,
	output reg  [7:0] o_infrared_pulse_width,
	output reg  [7:0] o_scratch,
	// Interrupt request, priority-encoded source and line status
	output wire       o_irq,
	output wire [3:0] o_source_code,
	output wire [7:0] o_line_status
);

	wire key_open = (o_line_control == `URM_LCR_KEY);
	wire div_open = o_line_control[`URM_LCR_DIV] & ~key_open;
	wire enh      = o_enhanced_function_ctrl[`URM_EFR_ENH];
	wire fifo_on  = o_fifo_control[`URM_FCR_EN];
	wire xfr_push = o_extra_feature_ctrl[`URM_XFR_LSRMODE];

	reg        data_ready;
	reg        overrun;
	reg  [2:0] err_push;
	reg        ls_pend;
	reg        tx_pend;
	reg        tx_empty_q;
	// Last error type seen, so bits 2-4 raise the line interrupt when they change to a nonzero value
	reg  [2:0] err_q;

	wire wr_std = i_wr & ~o_line_control[`URM_LCR_DIV];
	wire rd_std = i_rd & ~o_line_control[`URM_LCR_DIV];
	wire rd_lsr = rd_std & (i_addr == `URM_A_LSR);
	wire rd_isr = rd_std & (i_addr == `URM_A_ISR);
	wire wr_thr = wr_std & (i_addr == `URM_A_RXTX);
	wire wr_ier = wr_std & (i_addr == `URM_A_IER);

	wire [2:0] err_now = xfr_push ? err_push : i_rx_head_err;

	// ready / overrun / error type / tx and fifo flags
	assign o_line_status = {i_rx_any_err & fifo_on, i_tsr_empty & i_tx_empty, i_tx_empty,
		err_now, overrun, data_ready};

	// upper enables effective only when enhanced
	wire [7:0] ier_eff = enh ? o_interrupt_enable_mask
		: (o_interrupt_enable_mask & `URM_IER_LOW_M);

	wire rx_src = ier_eff[`URM_IER_RX] & (fifo_on ? i_rx_at_trigger : data_ready);
	wire to_src = ier_eff[`URM_IER_RX] & fifo_on & i_rx_timeout;
	wire ls_src = ier_eff[`URM_IER_LS] & ls_pend;
	wire tx_src = ier_eff[`URM_IER_TX] & tx_pend;
	wire ms_src = ier_eff[`URM_IER_MS] & i_modem_pending;

	assign o_source_code = ls_src ? `URM_ISR_LS :
		to_src ? `URM_ISR_RXTO :
		rx_src ? `URM_ISR_RX :
		tx_src ? `URM_ISR_TX :
		ms_src ? `URM_ISR_MS : `URM_ISR_NONE;
	assign o_irq = ls_src | to_src | rx_src | tx_src | ms_src;

	wire tx_cond = fifo_on ? i_tx_below_trigger : i_tx_empty;

	always @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_line_control           <= `URM_LCR_RST;
			o_baud_divisor_low       <= `URM_ZERO8;
			o_baud_divisor_high      <= `URM_ZERO8;
			o_enhanced_function_ctrl <= `URM_ZERO8;
			o_flow_resume_char_1     <= `URM_ZERO8;
			o_flow_resume_char_2     <= `URM_ZERO8;
			o_flow_pause_char_1      <= `URM_ZERO8;
			o_flow_pause_char_2      <= `URM_ZERO8;
			o_interrupt_enable_mask  <= `URM_ZERO8;
			o_fifo_control           <= `URM_ZERO8;
			o_modem_control          <= `URM_ZERO8;
			o_extra_feature_ctrl     <= `URM_ZERO8;
			o_infrared_pulse_width   <= `URM_ZERO8;
			o_scratch                <= `URM_ZERO8;
			data_ready               <= 1'b0;
			overrun                  <= 1'b0;
			err_push                 <= 3'h0;
			ls_pend                  <= 1'b0;
			tx_pend                  <= 1'b0;
			tx_empty_q               <= 1'b0;
			err_q                    <= 3'h0;
		end else begin
			tx_empty_q <= tx_cond;
			err_q      <= err_now;
			if (i_wr) begin
				if (i_addr == `URM_A_LCR) begin
					o_line_control <= i_wdata;
				end else if (key_open) begin
					// whole byte stored in field order
					if (i_addr == `URM_A_EFR) begin
						o_enhanced_function_ctrl <= i_wdata;
					end else if (i_addr == `URM_A_RES1) begin
						o_flow_resume_char_1 <= i_wdata;
					end else if (i_addr == `URM_A_RES2) begin
						o_flow_resume_char_2 <= i_wdata;
					end else if (i_addr == `URM_A_PAU1) begin
						o_flow_pause_char_1 <= i_wdata;
					end else if (i_addr == `URM_A_PAU2) begin
						o_flow_pause_char_2 <= i_wdata;
					end
				end else if (o_line_control[`URM_LCR_DIV]) begin
					if (i_addr == `URM_A_RXTX) begin
						o_baud_divisor_low <= i_wdata;
					end else if (i_addr == `URM_A_IER) begin
						o_baud_divisor_high <= i_wdata;
					end
				end else if (i_addr == `URM_A_IER) begin
					o_interrupt_enable_mask <= i_wdata;
				end else if (i_addr == `URM_A_ISR) begin
					// Other fifo-control bits only program with the enable bit set
					if (i_wdata[`URM_FCR_EN])
						o_fifo_control <= i_wdata;
					else
						o_fifo_control <= `URM_ZERO8;
				end else if (i_addr == `URM_A_MCR) begin
					o_modem_control <= i_wdata;
				end else if (i_addr == `URM_A_LSR) begin
					if (enh)
						o_extra_feature_ctrl <= i_wdata;
				end else if (i_addr == `URM_A_MSR) begin
					if (enh)
						o_infrared_pulse_width <= i_wdata;
				end else if (i_addr == `URM_A_SPR) begin
					o_scratch <= i_wdata;
				end
			end

			// ready set on push, cleared when empty; push wins
			if (i_rx_push)
				data_ready <= 1'b1;
			else if (i_rx_empty)
				data_ready <= 1'b0;

			if (i_rx_push)
				err_push <= i_rx_push_err;
			else if (rd_lsr)
				err_push <= 3'h0;

			// overrun sticky, set wins over clear
			if (i_rx_overrun)
				overrun <= 1'b1;
			else if (rd_lsr)
				overrun <= 1'b0;

			if (i_rx_overrun | ((err_now != err_q) & (|err_now))
				| (xfr_push & i_rx_push & (|i_rx_push_err)))
				ls_pend <= 1'b1;
			else if (rd_lsr)
				ls_pend <= 1'b0;

			if ((tx_cond & ~tx_empty_q) |
				(wr_ier & i_wdata[`URM_IER_TX] & ~o_interrupt_enable_mask[`URM_IER_TX]
				& tx_cond))
				tx_pend <= 1'b1;
			else if (rd_isr | wr_thr | ~tx_cond)
				tx_pend <= 1'b0;
		end
	end

	// revision and identifier when divisor is zero
	wire div_zero = (o_baud_divisor_low == `URM_ZERO8) & (o_baud_divisor_high == `URM_ZERO8);
	wire [1:0] isr_fifo = {fifo_on, fifo_on};

	always @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_rdata <= `URM_ZERO8;
		end else if (i_rd) begin
			if (key_open & (i_addr == `URM_A_EFR)) begin
				o_rdata <= o_enhanced_function_ctrl;
			end else if (key_open & (i_addr == `URM_A_RES1)) begin
				o_rdata <= o_flow_resume_char_1;
			end else if (key_open & (i_addr == `URM_A_RES2)) begin
				o_rdata <= o_flow_resume_char_2;
			end else if (key_open & (i_addr == `URM_A_PAU1)) begin
				o_rdata <= o_flow_pause_char_1;
			end else if (key_open & (i_addr == `URM_A_PAU2)) begin
				o_rdata <= o_flow_pause_char_2;
			end else if (i_addr == `URM_A_LCR) begin
				o_rdata <= o_line_control;
			end else if (div_open & (i_addr == `URM_A_RXTX)) begin
				o_rdata <= div_zero ? `URM_REVISION : o_baud_divisor_low;
			end else if (div_open & (i_addr == `URM_A_IER)) begin
				o_rdata <= div_zero ? `URM_DEV_ID : o_baud_divisor_high;
			end else if (o_line_control[`URM_LCR_DIV]) begin
				o_rdata <= `URM_ZERO8;
			end else if (i_addr == `URM_A_IER) begin
				o_rdata <= ier_eff;
			end else if (i_addr == `URM_A_ISR) begin
				o_rdata <= {isr_fifo, 2'b00, o_source_code};
			end else if (i_addr == `URM_A_MCR) begin
				o_rdata <= o_modem_control;
			end else if (i_addr == `URM_A_LSR) begin
				o_rdata <= o_line_status;
			end else if (i_addr == `URM_A_SPR) begin
				o_rdata <= o_scratch;
			end else begin
				o_rdata <= `URM_ZERO8;
			end
		end
	end

endmodule

// ===== testbench/urm_regbank_chk.sv
// Port-level assertions for the UART register bank
`timescale 1ns/10ps
`include "urm_regs.vh"
module urm_regbank_chk (
	input wire       i_clock,
	input wire       i_sys_rst,
	input wire [2:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_rd,
	input wire       i_rx_empty,
	input wire       i_rx_at_trigger,
	input wire       i_rx_overrun,
	input wire       i_tx_empty,
	input wire       i_tsr_empty,
	input wire [7:0] o_rdata,
	input wire [7:0] o_line_control,
	input wire [7:0] o_baud_divisor_low,
	input wire [7:0] o_baud_divisor_high,
	input wire [7:0] o_enhanced_function_ctrl,
	input wire [7:0] o_interrupt_enable_mask,
	input wire [7:0] o_fifo_control,
	input wire       o_irq,
	input wire [7:0] o_line_status
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// The key value closes divisor access even though its top bit is set
	sequence s_div_open;
		o_line_control[7] && o_line_control != 8'hbf;
	endsequence
	a_div_write: assert property (i_wr && i_addr == 3'h0 ##0 s_div_open |=>
		o_baud_divisor_low == $past(i_wdata)) else $error("divisor write lost");
	a_key_enh: assert property (i_wr && i_addr == 3'h2 && o_line_control == 8'hbf |=>
		o_enhanced_function_ctrl == $past(i_wdata)) else $error("enhanced write lost");
	a_rev_read: assert property (i_rd && i_addr == 3'h0 && o_baud_divisor_low == 8'h00 &&
		o_baud_divisor_high == 8'h00 ##0 s_div_open |=> o_rdata == `URM_REVISION)
		else $error("revision byte not returned");
	a_reset_mask: assert property ($fell(i_sys_rst) |->
		o_interrupt_enable_mask == 8'h00 && o_line_control == 8'h03) else $error("reset values");
	a_overrun_irq: assert property (i_rx_overrun && o_interrupt_enable_mask[2] && !i_wr |=>
		o_line_status[1] && o_irq) else $error("overrun not flagged");
	a_ready_clear: assert property ($fell(o_line_status[0]) |->
		$past(i_rx_empty) || i_rx_empty) else $error("ready dropped with data");
	a_tx_bits: assert property (o_line_status[6:5] ==
		{i_tx_empty && i_tsr_empty, i_tx_empty}) else $error("transmit empty bits");
	a_rx_trigger: assert property (o_interrupt_enable_mask[0] && o_fifo_control[0] &&
		i_rx_at_trigger |-> o_irq) else $error("trigger irq missing");
endmodule
bind urm_regbank urm_regbank_chk i_chk (.*);

// ===== testbench/urm_host.sv
// Host processor model for the register bank's parallel bus
`timescale 1ns/10ps
module urm_host (
	// Clock and read data
	input  wire       i_clock,
	input  wire [7:0] i_rdata,
	// Bus toward the device
	output reg  [2:0] o_addr = 3'h0,
	output reg  [7:0] o_wdata = 8'h00,
	output reg        o_wr = 1'b0,
	output reg        o_rd = 1'b0
);
	task wr(input [2:0] a, input [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clock);
		o_wr <= 1'b0;
		// Stale data is inverted so a late sample cannot pass by luck
		o_wdata <= ~d;
	endtask
	task rd(input [2:0] a, output [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clock);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
endmodule

// ===== testbench/uart_regmap_and_int_enable_bench.sv
// Self-checking bench for the UART register bank
`timescale 1ns/10ps
`include "urm_regs.vh"
module uart_regmap_and_int_enable_bench;
	reg        clock = 1'b0;
	reg        rst = 1'b1;
	reg        push = 1'b0;
	reg        rx_empty = 1'b1;
	reg        at_trig = 1'b0;
	reg        overrun = 1'b0;
	reg  [2:0] head_err = 3'h0;
	reg  [2:0] push_err = 3'h0;
	reg        any_err = 1'b0;
	reg        tx_empty = 1'b0;
	reg        tsr_empty = 1'b0;
	reg  [7:0] v;
	wire [2:0] addr;
	wire [7:0] wdata, rdata, extra, enh, line_st;
	wire       wr, rd, irq;
	wire [3:0] src;
	integer    mismatches = 0;
	integer    checks_done = 0;
	integer    cycles = 0;
	always #20 clock = ~clock;
	urm_host i_host (.i_clock(clock), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	urm_regbank i_dut (.i_clock(clock), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_push(push), .i_rx_empty(rx_empty),
		.i_rx_at_trigger(at_trig), .i_rx_timeout(1'b0), .i_rx_overrun(overrun),
		.i_rx_head_err(head_err), .i_rx_push_err(push_err), .i_rx_any_err(any_err),
		.i_tx_empty(tx_empty), .i_tx_below_trigger(tx_empty), .i_tsr_empty(tsr_empty),
		.i_modem_pending(1'b0), .o_line_control(), .o_baud_divisor_low(),
		.o_baud_divisor_high(), .o_enhanced_function_ctrl(enh), .o_flow_resume_char_1(),
		.o_flow_resume_char_2(), .o_flow_pause_char_1(), .o_flow_pause_char_2(),
		.o_interrupt_enable_mask(), .o_fifo_control(), .o_modem_control(),
		.o_extra_feature_ctrl(extra), .o_infrared_pulse_width(), .o_scratch(), .o_irq(irq),
		.o_source_code(src), .o_line_status(line_st));
	task tick(input integer n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task chk(input string nm, input [7:0] e, input [7:0] g);
		checks_done = checks_done + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("Error %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task rchk(input [2:0] a, input [7:0] e, input string nm);
		i_host.rd(a, v);
		chk(nm, e, v);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task t_reset;
		rchk(3'h1, 8'h00, "enable mask");
		rchk(3'h3, 8'h03, "line control");
	endtask
	task t_divisor;
		i_host.wr(3'h3, 8'h80);
		rchk(3'h0, `URM_REVISION, "revision");
		rchk(3'h1, `URM_DEV_ID, "identifier");
		i_host.wr(3'h0, 8'h12);
		i_host.wr(3'h1, 8'h34);
		rchk(3'h0, 8'h12, "divisor low");
		rchk(3'h1, 8'h34, "divisor high");
		i_host.wr(3'h3, 8'h03);
	endtask
	task t_enhanced;
		integer a;
		i_host.wr(3'h5, 8'h08);
		tick(1);
		chk("extra feature", 8'h00, extra);
		i_host.wr(3'h3, 8'hbf);
		i_host.wr(3'h2, 8'hd5);
		for (a = 4; a < 8; a = a + 1)
			i_host.wr(a[2:0], 8'h40 + a[7:0]);
		for (a = 4; a < 8; a = a + 1)
			rchk(a[2:0], 8'h40 + a[7:0], "flow char");
		rchk(3'h2, 8'hd5, "enhanced");
		i_host.wr(3'h3, 8'h03);
		rchk(3'h2, 8'h01, "source status");
		i_host.wr(3'h5, 8'h08);
		tick(1);
		chk("extra feature", 8'h08, extra);
		i_host.wr(3'h5, 8'h00);
	endtask
	task t_status;
		i_host.wr(3'h2, 8'h01);
		@(posedge clock);
		tx_empty <= 1'b1;
		head_err <= 3'b101;
		any_err <= 1'b1;
		push <= 1'b1;
		rx_empty <= 1'b0;
		@(posedge clock);
		push <= 1'b0;
		tick(3);
		chk("line status", 8'hb5, line_st);
		@(posedge clock);
		tsr_empty <= 1'b1;
		rx_empty <= 1'b1;
		head_err <= 3'h0;
		any_err <= 1'b0;
		tick(2);
		chk("line status", 8'h60, line_st);
		rchk(3'h5, 8'h60, "line status read");
	endtask
	task t_irq;
		i_host.wr(3'h1, 8'h02);
		tick(1);
		chk("irq", 8'h01, {7'h0, irq});
		rchk(3'h2, 8'hc2, "source status");
		chk("irq", 8'h00, {7'h0, irq});
		i_host.wr(3'h1, 8'h04);
		@(posedge clock);
		overrun <= 1'b1;
		@(posedge clock);
		overrun <= 1'b0;
		tick(1);
		chk("source", 8'h06, {4'h0, src});
		rchk(3'h5, 8'h62, "line status read");
		chk("irq", 8'h00, {7'h0, irq});
		i_host.wr(3'h1, 8'h00);
		@(posedge clock);
		at_trig <= 1'b1;
		tick(1);
		chk("irq", 8'h00, {7'h0, irq});
		i_host.wr(3'h1, 8'h01);
		tick(1);
		chk("source", 8'h04, {4'h0, src});
		@(posedge clock);
		at_trig <= 1'b0;
		tick(1);
		chk("irq", 8'h00, {7'h0, irq});
		// Errors reported on reception when extra-feature bit 3 is set
		i_host.wr(3'h5, 8'h08);
		i_host.wr(3'h1, 8'h04);
		@(posedge clock);
		push_err <= 3'b010;
		push <= 1'b1;
		@(posedge clock);
		push <= 1'b0;
		push_err <= 3'h0;
		tick(1);
		chk("source", 8'h06, {4'h0, src});
		i_host.rd(3'h5, v);
		chk("irq", 8'h00, {7'h0, irq});
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_divisor;
		t_enhanced;
		t_status;
		t_irq;
		wrap_up;
	end
	// Whole run needs about a hundred cycles; a hang ends here
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			mismatches = mismatches + 1;
			wrap_up;
		end
	end
endmodule
